// ### rtl/crt_timing_and_buffer_handshake.sv
// Purpose: Raster timing, cursor gate, interrupt pin and display address bus.
// Assumes: Configuration is stable while displaying; inputs synchronous to clk.
// Notes:   ce is the character clock; with ce low every flip-flop holds.
//
// How it works
// - Horizontal sync active high, programmable timing.
// - Shared sync output: vertical or composite with equalization.
// - Blank high outside active area.
// - Bus flags valid at blank trailing edge.
// - Cursor gate on address match, line span, blink.
// - Row-table mode: cursor during row address fetch.
// - Interrupt pin low when enabled source pending.
// - Interrupt pin released after reset or master reset.
// - Mains lock low stretches front porch by lines.
// - Independent mode: pin one is write strobe.
// - Independent mode: pin two is read strobe.
// - On request, float bus, pin two low.
// - Display-off float command drives pin two low.
// - Row-buffer mode: pin two halts CPU.
// - Independent mode: pin three is chip select.
// - Shared modes: pin three low as ready.
// - Row-buffer mode: pin three high steers bus.
// - 16k direct, bits 14 and 15 multiplexed.
// - Address bus floats depending on buffer mode.
// - Line 0 carries graphics flag in blanking.
// - Line 3 final row, lines 4-7 scan line.
// - Lines 8 and 13 first and last line.
// - Line 10 carries underline position marker.
// - Line 12 carries odd-field flag under interlace.
`timescale 1ns/100ps
module crt_timing_and_buffer_handshake (
	// Clock, reset and character clock enable.
	input  wire logic                       clk,
	input  wire logic                       rstn,
	input  wire logic                       ce,
	// Configuration.
	input  wire crt_pkg::crt_cfg_t          cfg,
	input  wire logic                       mainsLock,
	// Interrupt sources.
	input  wire logic [crt_pkg::IRQ_N-1:0]  irqEvent,
	input  wire logic [crt_pkg::IRQ_N-1:0]  irqMask,
	input  wire logic [crt_pkg::IRQ_N-1:0]  irqClear,
	input  wire logic                       masterReset,
	// Buffer handshake.
	input  wire logic                       pin1In,
	input  wire logic                       latchWrite,
	input  wire logic                       latchRead,
	output logic                            pin1Out,
	output logic                            pin1Oen,
	output logic                            pin2,
	output logic                            pin3,
	// Monitor timing.
	output crt_pkg::crt_video_t             video,
	// Interrupt pin, open drain.
	output logic                            irqOut,
	output logic                            irqOen,
	// Display address bus.
	output logic [crt_pkg::BUS_W-1:0]       addrOut,
	output logic [crt_pkg::BUS_W-1:0]       addrOen
);

	// --------------------------------------------------------
	// State
	// --------------------------------------------------------
	typedef struct packed {
		logic [7:0]                 hCnt;
		logic [3:0]                 scan;
		logic [6:0]                 row;
		logic [7:0]                 vCnt;
		crt_pkg::crt_vstate_t       vState;
		logic                       oddField;
		logic [7:0]                 frame;
		logic [15:0]                rowStart;
		crt_pkg::crt_video_t        vid;
		logic [crt_pkg::BUS_W-1:0]  bus;
		logic                       rowDmaWin;
		logic [crt_pkg::IRQ_N-1:0]  irqPend;
		logic                       irqDrive;
	} crt_state_t;

	crt_state_t       s_q;
	crt_state_t       s_d;
	crt_pkg::crt_hs_t hs;

	// Scratch terms of the next-state logic.
	logic        lineEnd;
	logic        porchDone;
	logic [7:0]  vLimit;
	logic [7:0]  halfLine;
	logic [7:0]  hsWidth;
	logic [7:0]  eqWidth;
	logic [7:0]  posHalf;
	logic        eqPulse;
	logic        serrated;
	logic        eqZone;
	logic [15:0] charAddr;
	logic [15:0] upStart;
	logic        upFirst;
	logic [3:0]  upScan;
	logic [6:0]  upRow;
	logic        upLastRow;
	logic        inHBlank;
	logic [8:0]  fetchEnd;
	logic [8:0]  porchSum;

	// True when a scan line lies within an inclusive span.
	function automatic logic inSpan(input logic [3:0] v, input logic [3:0] lo, input logic [3:0] hi);
		inSpan = (v >= lo) && (v <= hi);
	endfunction

	// --------------------------------------------------------
	// Raster counters
	// --------------------------------------------------------
	// Vertical counts start at one so a programmed count of N lines
	// gives exactly N lines; a count of zero behaves as one.
	always_comb
	begin
		s_d       = s_q;
		lineEnd   = (s_q.hCnt == cfg.hTotal);
		s_d.hCnt  = lineEnd ? 8'h00 : 8'(s_q.hCnt + 8'h01);
		vLimit    = 8'h00;
		porchDone = 1'b0;
		unique case (s_q.vState)
			crt_pkg::V_ACTIVE: vLimit = 8'h00;
			crt_pkg::V_FRONT:  vLimit = cfg.vFront;
			crt_pkg::V_SYNC:   vLimit = cfg.vSync;
			crt_pkg::V_BACK:   vLimit = cfg.vBack;
		endcase
		porchDone = (s_q.vCnt >= vLimit);
		if (lineEnd)
		begin
			unique case (s_q.vState)
				crt_pkg::V_ACTIVE:
				begin
					if (s_q.scan == cfg.lastScan)
					begin
						s_d.scan = 4'h0;
						if (s_q.row == cfg.lastRow)
						begin
							s_d.vState = crt_pkg::V_FRONT;
							s_d.vCnt   = crt_pkg::V_COUNT_FIRST;
						end
						else
						begin
							s_d.row      = 7'(s_q.row + 7'h01);
							s_d.rowStart = 16'(s_q.rowStart + {8'h00, cfg.hActive});
						end
					end
					else
						s_d.scan = 4'(s_q.scan + 4'h1);
				end
				crt_pkg::V_FRONT:
				begin
					// Porch is held whole lines at a time until the mains input is high.
					if (porchDone && mainsLock)
					begin
						s_d.vState = crt_pkg::V_SYNC;
						s_d.vCnt   = crt_pkg::V_COUNT_FIRST;
					end
					else if (!porchDone)
						s_d.vCnt = 8'(s_q.vCnt + 8'h01);
				end
				crt_pkg::V_SYNC:
				begin
					if (porchDone)
					begin
						s_d.vState = crt_pkg::V_BACK;
						s_d.vCnt   = crt_pkg::V_COUNT_FIRST;
					end
					else
						s_d.vCnt = 8'(s_q.vCnt + 8'h01);
				end
				crt_pkg::V_BACK:
				begin
					if (porchDone)
					begin
						s_d.vState   = crt_pkg::V_ACTIVE;
						s_d.row      = 7'h00;
						s_d.scan     = 4'h0;
						s_d.rowStart = cfg.startAddr;
						s_d.frame    = 8'(s_q.frame + 8'h01);
						s_d.oddField = cfg.interlace && !s_q.oddField;
					end
					else
						s_d.vCnt = 8'(s_q.vCnt + 8'h01);
				end
			endcase
		end

		// ----------------------------------------------------
		// Sync and blank for the coming character
		// ----------------------------------------------------
		s_d.vid.hSync = (s_d.hCnt >= cfg.hSyncStart) && (s_d.hCnt < cfg.hSyncEnd);
		s_d.vid.blank = (s_d.vState != crt_pkg::V_ACTIVE) || (s_d.hCnt >= cfg.hActive)
			|| !cfg.displayOn;
		// Equalizing and serration pulses run at twice line rate.
		halfLine = {1'b0, cfg.hTotal[7:1]};
		hsWidth  = 8'(cfg.hSyncEnd - cfg.hSyncStart);
		eqWidth  = {1'b0, hsWidth[7:1]};
		posHalf  = (s_d.hCnt >= halfLine) ? 8'(s_d.hCnt - halfLine) : s_d.hCnt;
		eqPulse  = (posHalf < eqWidth);
		serrated = (posHalf < 8'(halfLine - hsWidth));
		porchSum = 9'({1'b0, s_d.vCnt} + crt_pkg::EQ_LINES);
		eqZone   = ((s_d.vState == crt_pkg::V_FRONT) && (porchSum > {1'b0, cfg.vFront}))
			|| ((s_d.vState == crt_pkg::V_BACK) && ({1'b0, s_d.vCnt} <= crt_pkg::EQ_LINES));
		if (cfg.compositeSel)
		begin
			if (s_d.vState == crt_pkg::V_SYNC)
				s_d.vid.syncOut = serrated;
			else if (eqZone)
				s_d.vid.syncOut = eqPulse;
			else
				s_d.vid.syncOut = s_d.vid.hSync;
		end
		else
			s_d.vid.syncOut = (s_d.vState == crt_pkg::V_SYNC);

		// ----------------------------------------------------
		// Look ahead to the next scan line for the blanking flags
		// ----------------------------------------------------
		// Flags must describe the line that follows the blank, so
		// they are built from the line about to start.
		charAddr = 16'(s_d.rowStart + {8'h00, s_d.hCnt});
		upFirst  = (s_d.vState != crt_pkg::V_ACTIVE) || (s_d.scan == cfg.lastScan);
		upScan   = upFirst ? 4'h0 : 4'(s_d.scan + 4'h1);
		if (s_d.vState != crt_pkg::V_ACTIVE)
		begin
			upRow   = 7'h00;
			upStart = cfg.startAddr;
		end
		else if (upFirst)
		begin
			upRow   = 7'(s_d.row + 7'h01);
			upStart = 16'(s_d.rowStart + {8'h00, cfg.hActive});
		end
		else
		begin
			upRow   = s_d.row;
			upStart = s_d.rowStart;
		end
		upLastRow = (upRow == cfg.lastRow);
		inHBlank  = (s_d.hCnt >= cfg.hActive);

		// ----------------------------------------------------
		// Display address bus
		// ----------------------------------------------------
		if (s_d.vid.blank)
		begin
			s_d.bus                     = '0;
			s_d.bus[crt_pkg::FLG_GFX]   = cfg.graphics;
			s_d.bus[crt_pkg::FLG_A14]   = upStart[14];
			s_d.bus[crt_pkg::FLG_A15]   = upStart[15];
			s_d.bus[crt_pkg::FLG_LROW]  = upLastRow;
			s_d.bus[crt_pkg::FLG_SCAN +: 4] = upScan;
			s_d.bus[crt_pkg::FLG_FIRST] = upFirst;
			s_d.bus[crt_pkg::FLG_DW]    = cfg.doubleWidth;
			s_d.bus[crt_pkg::FLG_UNDER] = (upScan == cfg.underlinePos);
			s_d.bus[crt_pkg::FLG_BLINK] = s_d.frame[crt_pkg::CHR_BLINK_BIT];
			s_d.bus[crt_pkg::FLG_ODD]   = cfg.interlace && s_d.oddField;
			s_d.bus[crt_pkg::FLG_LLINE] = (upScan == cfg.lastScan);
		end
		else
			s_d.bus = charAddr[crt_pkg::BUS_W-1:0];

		// ----------------------------------------------------
		// Cursor gate and row fetch window
		// ----------------------------------------------------
		fetchEnd = 9'({1'b0, cfg.hActive} + {1'b0, crt_pkg::ROW_FETCH_CHARS});
		s_d.rowDmaWin = upFirst && inHBlank && (upRow <= cfg.lastRow)
			&& (s_d.vState == crt_pkg::V_ACTIVE || s_d.vCnt >= vLimit);
		s_d.vid.cursor = (!s_d.vid.blank && (charAddr == cfg.cursorAddr)
			&& inSpan(s_d.scan, cfg.cursorFirst, cfg.cursorLast)
			&& (!cfg.cursorBlink || s_d.frame[crt_pkg::CUR_BLINK_BIT]))
			|| (cfg.rowTable && s_d.rowDmaWin && ({1'b0, s_d.hCnt} < fetchEnd));

		// ----------------------------------------------------
		// Interrupt pending and pin drive
		// ----------------------------------------------------
		// A new event in the cycle of its clear is kept.
		s_d.irqPend  = (s_q.irqPend & ~(irqClear | {crt_pkg::IRQ_N{masterReset}})) | irqEvent;
		s_d.irqDrive = |(s_d.irqPend & irqMask);
	end

	// --------------------------------------------------------
	// State register
	// --------------------------------------------------------
	// Outputs are flops clocked only on character clocks, except irqOut, which is tied low.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			s_q          <= '0;
			s_q.vState   <= crt_pkg::V_FRONT;
			s_q.vCnt     <= crt_pkg::V_COUNT_FIRST;
			s_q.vid.blank <= 1'b1;
			s_q.irqPend  <= crt_pkg::IRQ_PEND_RST;
		end
		else if (ce)
			s_q <= s_d;
	end

	// --------------------------------------------------------
	// Buffer handshake pins
	// --------------------------------------------------------
	crt_buffer_handshake u_hs (
		.clk        (clk),
		.rstn       (rstn),
		.ce         (ce),
		.mode       (cfg.bufMode),
		.cpuReqN    (pin1In),
		.blanking   (s_q.vid.blank),
		.offFloat   (cfg.offFloatCmd),
		.rowDmaWin  (s_q.rowDmaWin),
		.latchWrite (latchWrite),
		.latchRead  (latchRead),
		.hs         (hs)
	);

	// --------------------------------------------------------
	// Output pins
	// --------------------------------------------------------
	assign video   = s_q.vid;
	assign addrOut = s_q.bus;
	assign addrOen = {crt_pkg::BUS_W{hs.addrFloat}};
	assign irqOut  = 1'b0;
	assign irqOen  = !s_q.irqDrive;
	assign pin1Out = hs.pin1Out;
	assign pin1Oen = hs.pin1Oen;
	assign pin2    = hs.pin2;
	assign pin3    = hs.pin3;

endmodule

// ### pkg/crt_pkg.sv
// Purpose: Shared constants and types for the raster timing and buffer handshake block.
// Assumes: One character clock per enabled clk cycle.
// Notes:   Widths are fixed; timing values arrive as a configuration struct.
package crt_pkg;

	// ----------------------------------------
	// Widths and constants
	// ----------------------------------------
	localparam int unsigned ADDR_W   = 16;
	localparam int unsigned BUS_W    = 14;
	localparam int unsigned IRQ_N    = 5;
	localparam logic [7:0]  ROW_FETCH_CHARS = 8'h04;
	localparam logic [8:0]  EQ_LINES        = 9'h003;
	localparam int unsigned CUR_BLINK_BIT   = 4;
	localparam int unsigned CHR_BLINK_BIT   = 5;
	localparam logic        PIN_IDLE        = 1'b1;
	localparam logic [4:0]  IRQ_PEND_RST    = 5'h00;
	localparam logic [7:0]  V_COUNT_FIRST   = 8'h01;

	// ----------------------------------------
	// Positions of flags on the address bus during blanking
	// ----------------------------------------
	localparam int unsigned FLG_GFX   = 0;
	localparam int unsigned FLG_A14   = 1;
	localparam int unsigned FLG_A15   = 2;
	localparam int unsigned FLG_LROW  = 3;
	localparam int unsigned FLG_SCAN  = 4;
	localparam int unsigned FLG_FIRST = 8;
	localparam int unsigned FLG_DW    = 9;
	localparam int unsigned FLG_UNDER = 10;
	localparam int unsigned FLG_BLINK = 11;
	localparam int unsigned FLG_ODD   = 12;
	localparam int unsigned FLG_LLINE = 13;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		BUF_INDEP  = 2'h0,
		BUF_TRANSP = 2'h1,
		BUF_SHARED = 2'h2,
		BUF_ROWBUF = 2'h3
	} crt_bufmode_t;

	typedef enum logic [1:0] {
		V_ACTIVE = 2'h0,
		V_FRONT  = 2'h1,
		V_SYNC   = 2'h2,
		V_BACK   = 2'h3
	} crt_vstate_t;

	typedef struct packed {
		logic [7:0]   hTotal;
		logic [7:0]   hActive;
		logic [7:0]   hSyncStart;
		logic [7:0]   hSyncEnd;
		logic [3:0]   lastScan;
		logic [6:0]   lastRow;
		logic [7:0]   vFront;
		logic [7:0]   vSync;
		logic [7:0]   vBack;
		logic         compositeSel;
		logic         interlace;
		logic [3:0]   underlinePos;
		logic [3:0]   cursorFirst;
		logic [3:0]   cursorLast;
		logic         cursorBlink;
		logic         rowTable;
		logic         graphics;
		logic         doubleWidth;
		logic         displayOn;
		logic         offFloatCmd;
		logic [15:0]  startAddr;
		logic [15:0]  cursorAddr;
		crt_bufmode_t bufMode;
	} crt_cfg_t;

	typedef struct packed {
		logic hSync;
		logic syncOut;
		logic blank;
		logic cursor;
	} crt_video_t;

	typedef struct packed {
		logic pin1Out;
		logic pin1Oen;
		logic pin2;
		logic pin3;
		logic addrFloat;
	} crt_hs_t;

endpackage

// ### rtl/crt_buffer_handshake.sv
// Purpose: Mode dependent handshake pins toward display memory and CPU.
// Assumes: Inputs are synchronous to clk; ce marks character clocks.
// Notes:   All pin levels come from flip-flops.
`timescale 1ns/100ps
module crt_buffer_handshake (
	// Clock and reset.
	input  wire logic                  clk,
	input  wire logic                  rstn,
	input  wire logic                  ce,
	// Mode and requests.
	input  wire crt_pkg::crt_bufmode_t mode,
	input  wire logic                  cpuReqN,
	input  wire logic                  blanking,
	input  wire logic                  offFloat,
	input  wire logic                  rowDmaWin,
	input  wire logic                  latchWrite,
	input  wire logic                  latchRead,
	// Pin levels.
	output crt_pkg::crt_hs_t           hs
);

	typedef struct packed {
		logic             released;
		crt_pkg::crt_hs_t pins;
	} crt_hs_state_t;

	crt_hs_state_t s_q;
	crt_hs_state_t s_d;
	logic          wr;
	logic          rd;
	logic          shareMode;

	// --------------------------------------------------------
	// Next state
	// --------------------------------------------------------
	// Transparent mode only lets go of memory while blanked, to keep the raster clean.
	always_comb
	begin
		s_d       = s_q;
		shareMode = (mode == crt_pkg::BUF_TRANSP) || (mode == crt_pkg::BUF_SHARED);
		wr        = latchWrite;
		rd        = latchRead && !latchWrite; // Write wins a tie.
		s_d.pins.pin1Out = crt_pkg::PIN_IDLE;
		s_d.pins.pin1Oen = crt_pkg::PIN_IDLE;
		s_d.pins.pin2    = crt_pkg::PIN_IDLE;
		s_d.pins.pin3    = crt_pkg::PIN_IDLE;
		if (!shareMode || cpuReqN)
			s_d.released = 1'b0;
		else if (mode == crt_pkg::BUF_SHARED || blanking)
			s_d.released = 1'b1;
		unique case (mode)
			crt_pkg::BUF_INDEP:
			begin
				s_d.pins.pin1Oen = 1'b0;
				s_d.pins.pin1Out = !wr;
				s_d.pins.pin2    = !rd;
				s_d.pins.pin3    = !(wr || rd);
			end
			crt_pkg::BUF_TRANSP, crt_pkg::BUF_SHARED:
			begin
				s_d.pins.pin2 = !(s_d.released || offFloat);
				s_d.pins.pin3 = !s_d.released;
			end
			crt_pkg::BUF_ROWBUF:
			begin
				s_d.pins.pin2 = !(rowDmaWin || offFloat);
				s_d.pins.pin3 = rowDmaWin;
			end
		endcase
		if (mode == crt_pkg::BUF_INDEP && offFloat)
			s_d.pins.pin2 = 1'b0;
		s_d.pins.addrFloat = s_d.released || offFloat || (mode == crt_pkg::BUF_ROWBUF && rowDmaWin);
	end

	// --------------------------------------------------------
	// State register
	// --------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			s_q           <= '0;
			s_q.pins.pin1Out <= crt_pkg::PIN_IDLE;
			s_q.pins.pin1Oen <= crt_pkg::PIN_IDLE;
			s_q.pins.pin2    <= crt_pkg::PIN_IDLE;
			s_q.pins.pin3    <= crt_pkg::PIN_IDLE;
		end
		else if (ce)
			s_q <= s_d;
	end

	assign hs = s_q.pins;

endmodule

// ### dv/crt_timing_monitor.sv
// Purpose: Port level assertions for the raster timing and handshake block.
// Assumes: ce is high apart from short freezes in which every pin holds.
// Notes:   Configuration is taken as stable across the checked windows.
`timescale 1ns/100ps
module crt_timing_monitor (
	// Clock and reset.
	input wire logic                      clk,
	input wire logic                      rstn,
	// Controls.
	input wire crt_pkg::crt_cfg_t         cfg,
	input wire logic                      mainsLock,
	input wire logic [crt_pkg::IRQ_N-1:0] irqEvent,
	input wire logic [crt_pkg::IRQ_N-1:0] irqMask,
	input wire logic                      masterReset,
	input wire logic                      pin1In,
	input wire logic                      latchWrite,
	input wire logic                      latchRead,
	// Observed pins.
	input wire logic                      pin1Out,
	input wire logic                      pin1Oen,
	input wire logic                      pin2,
	input wire logic                      pin3,
	input wire crt_pkg::crt_video_t       video,
	input wire logic                      irqOen,
	input wire logic [crt_pkg::BUS_W-1:0] addrOen
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// ----------------------------------------
	// Request and release steps of the BUF_SHARED buffer mode
	// ----------------------------------------
	sequence reqSeen;
		cfg.bufMode == crt_pkg::BUF_SHARED && !pin1In && !cfg.offFloatCmd;
	endsequence
	sequence released;
		!pin2 && !pin3 && (&addrOen);
	endsequence
	wire indep = (cfg.bufMode == crt_pkg::BUF_INDEP);

	chk_reset_idle: assert property ($rose(rstn) |-> irqOen && pin2 && pin3 && video.blank)
		else $error("pins not idle after reset");
	chk_irq_pull: assert property (|(irqEvent & irqMask) |-> ##[1:2] !irqOen)
		else $error("interrupt not pulled");
	chk_irq_master: assert property (masterReset && irqEvent == '0 |-> ##[1:2] irqOen)
		else $error("interrupt not released by master reset");
	chk_lock_stall: assert property ((!cfg.compositeSel && !mainsLock) [*2] |-> !$rose(video.syncOut))
		else $error("sync started while lock low");
	chk_write_strobe: assert property (indep && latchWrite |=> !pin1Out && !pin1Oen && !pin3)
		else $error("write strobe missing");
	chk_read_strobe: assert property (indep && latchRead && !latchWrite |=> !pin2 && !pin3 && pin1Oen | pin1Out)
		else $error("read strobe wrong");
	chk_pins_idle: assert property (indep && $stable(cfg.bufMode) && !latchWrite && !latchRead
		&& !cfg.offFloatCmd |=> pin2 && pin3)
		else $error("strobe without request");
	chk_bus_release: assert property (reqSeen |-> ##1 released)
		else $error("bus not released on request");
	chk_off_float: assert property (cfg.offFloatCmd [*2] |-> !pin2 && (&addrOen))
		else $error("off command did not float bus");
	chk_cursor_blank: assert property (video.cursor && !$past(cfg.rowTable) |-> !video.blank)
		else $error("cursor during blank");
endmodule

bind crt_timing_and_buffer_handshake crt_timing_monitor crt_timing_monitor_i (.clk(clk), .rstn(rstn), .cfg(cfg),
	.mainsLock(mainsLock), .irqEvent(irqEvent), .irqMask(irqMask), .masterReset(masterReset), .pin1In(pin1In),
	.latchWrite(latchWrite), .latchRead(latchRead), .pin1Out(pin1Out), .pin1Oen(pin1Oen), .pin2(pin2),
	.pin3(pin3), .video(video), .irqOen(irqOen), .addrOen(addrOen));

// ### dv/crt_cpu_model.sv
// Purpose: Host CPU side of handshake pin one in the shared buffer modes.
// Assumes: reqGo is a level from the bench; pin one has a pull-up.
// Notes:   A request is held until the ready pin is seen low, even if reqGo drops.
`timescale 1ns/100ps
module crt_cpu_model (
	// Clock and control.
	input  wire logic clk,
	input  wire logic reqGo,
	// Pin one drive of the device and ready pin.
	input  wire logic pin1Out,
	input  wire logic pin1Oen,
	input  wire logic pin3,
	// Resolved pin one level.
	output wire logic pin1In
);
	logic reqN = 1'b1;

	// Open-drain style resolution: either party pulling low wins over the pull-up.
	assign pin1In = reqN & (pin1Oen | pin1Out);

	// Request low while access is wanted; release only after ready was seen.
	always @(posedge clk)
	begin
		if (reqN && reqGo)
			reqN <= #1 1'b0;
		else if (!reqN && !reqGo && !pin3)
			reqN <= #1 1'b1;
	end
endmodule

// ### dv/crt_tb.sv
// Purpose: Self-checking bench for raster timing, interrupt and handshake pins.
// Assumes: ce high except one short freeze; small raster of 20 chars by 10 lines, 200 cycles a frame.
// Notes:   Inputs change 1 ns after the rising edge, outputs are read there too.
`timescale 1ns/100ps
module testbench;
	logic clk = 1'b0, rstn = 1'b0, mainsLock = 1'b1, masterReset = 1'b0, reqGo = 1'b0, ce = 1'b1;
	logic latchWrite = 1'b0, latchRead = 1'b0, pin1In, pin1Out, pin1Oen, pin2, pin3, irqOut, irqOen;
	logic [crt_pkg::IRQ_N-1:0] irqEvent = '0, irqMask = '0, irqClear = '0;
	logic [crt_pkg::BUS_W-1:0] addrOut, addrOen;
	crt_pkg::crt_cfg_t         cfg = '0;
	crt_pkg::crt_video_t       video;
	int err_total = 0, total_checks = 0;

	// Half period of 4 ns gives the 125 MHz clock.
	always #4 clk = ~clk;

	crt_timing_and_buffer_handshake crt_timing_and_buffer_handshake_i (.clk(clk), .rstn(rstn), .ce(ce),
		.cfg(cfg), .mainsLock(mainsLock), .irqEvent(irqEvent), .irqMask(irqMask), .irqClear(irqClear),
		.masterReset(masterReset), .pin1In(pin1In), .latchWrite(latchWrite), .latchRead(latchRead),
		.pin1Out(pin1Out), .pin1Oen(pin1Oen), .pin2(pin2), .pin3(pin3), .video(video), .irqOut(irqOut),
		.irqOen(irqOen), .addrOut(addrOut), .addrOen(addrOen));
	crt_cpu_model crt_cpu_model_i (.clk(clk), .reqGo(reqGo), .pin1Out(pin1Out), .pin1Oen(pin1Oen),
		.pin3(pin3), .pin1In(pin1In));

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("checks %0d, mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Counts syncOut rises, cursor and hSync cycles over n cycles.
	task count(input int n, output int rises, output int curs, output int hs);
		logic prev;
		rises = 0;
		curs = 0;
		hs = 0;
		repeat (n)
		begin
			prev = video.syncOut;
			tick(1);
			rises += (!prev && video.syncOut);
			curs += video.cursor;
			hs += video.hSync;
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_raster;
		int r, c, h, bl;
		wait (video.blank == 1'b0);
		tick(1);
		bl = 0;
		h = 0;
		repeat (20)
		begin
			bl += video.blank;
			h += video.hSync;
			tick(1);
		end
		chk(bl, 8);
		chk(h, 3);
		wait (video.syncOut);
		tick(1);
		for (c = 1; video.syncOut && c < 100; c++)
			tick(1);
		chk(c, 40);
		count(200, r, c, h);
		chk(c, 2);
		cfg.compositeSel = 1'b1;
		count(400, r, c, h);
		chk(r > 10, 1);
		cfg.compositeSel = 1'b0;
		// One edge so that syncOut no longer shows composite pulses.
		tick(1);
		$display("raster test done");
	endtask
	task t_flags;
		logic [13:0] pa;
		logic pb;
		int n;
		// Sample off the edge so that bus and blank are both settled.
		while (!video.syncOut)
			tick(1);
		while (video.syncOut)
			tick(1);
		for (n = 0; n < 4; )
		begin
			pa = addrOut;
			pb = video.blank;
			tick(1);
			if (pb && !video.blank)
			begin
				chk(pa[0], 1);
				chk(pa[8], !n[0]);
				chk(pa[13], n[0]);
				chk(pa[10], n[0]);
				chk(pa[7:4], n[0]);
				chk(pa[3], n[1]);
				chk(addrOut, n[1] ? 16'h012F : 16'h0123);
				n++;
			end
		end
		$display("flag test done");
	endtask
	task t_lock;
		int r, c, h;
		while (video.syncOut)
			tick(1);
		mainsLock = 1'b0;
		count(300, r, c, h);
		chk(r, 0);
		mainsLock = 1'b1;
		count(25, r, c, h);
		chk(r, 1);
		$display("lock test done");
	endtask
	task t_irq;
		for (int i = 0; i < crt_pkg::IRQ_N; i++)
		begin
			irqMask = 5'h01 << i;
			irqEvent = 5'h01 << i;
			tick(1);
			irqEvent = '0;
			tick(2);
			chk({irqOut, irqOen}, 0);
			irqClear = 5'h1F;
			tick(1);
			irqClear = '0;
			tick(2);
			chk(irqOen, 1);
		end
		irqMask = '0;
		irqEvent = 5'h01;
		tick(1);
		irqEvent = '0;
		tick(2);
		chk(irqOen, 1);
		irqMask = 5'h01;
		tick(3);
		chk(irqOen, 0);
		masterReset = 1'b1;
		tick(1);
		masterReset = 1'b0;
		tick(2);
		chk(irqOen, 1);
		$display("interrupt test done");
	endtask
	// With ce low the address bus and video outputs must hold their values.
	task t_hold;
		logic [13:0] a;
		logic [3:0]  v;
		a = addrOut;
		v = video;
		ce = 1'b0;
		tick(3);
		chk(addrOut, a);
		chk(video, v);
		ce = 1'b1;
		$display("hold test done");
	endtask
	task t_indep;
		latchWrite = 1'b1;
		latchRead = 1'b1;
		tick(1);
		latchWrite = 1'b0;
		chk({pin1Out, pin1Oen, pin2, pin3}, 4'h2);
		tick(1);
		latchRead = 1'b0;
		chk({pin1Oen | pin1Out, pin2, pin3}, 3'h4);
		tick(1);
		chk({pin2, pin3}, 3);
		$display("independent test done");
	endtask
	task t_shared(input crt_pkg::crt_bufmode_t m);
		int n;
		cfg.bufMode = m;
		tick(2);
		reqGo = 1'b1;
		for (n = 0; pin3 && n < 400; n++)
			tick(1);
		chk(n < 400, 1);
		chk({pin2, addrOen}, 15'h3FFF);
		reqGo = 1'b0;
		tick(4);
		chk({pin2, pin3, addrOen}, 16'hC000);
		$display("shared test done");
	endtask
	task t_rowbuf;
		int dma, cb;
		cfg.bufMode = crt_pkg::BUF_ROWBUF;
		cfg.rowTable = 1'b1;
		dma = 0;
		cb = 0;
		repeat (200)
		begin
			tick(1);
			dma += (!pin2 && pin3);
			cb += (video.cursor && video.blank);
		end
		chk(dma > 0, 1);
		chk(cb > 0, 1);
		cfg.offFloatCmd = 1'b1;
		tick(2);
		chk({pin2, addrOen}, 15'h3FFF);
		cfg.offFloatCmd = 1'b0;
		cfg.rowTable = 1'b0;
		cfg.bufMode = crt_pkg::BUF_INDEP;
		tick(2);
		$display("row buffer test done");
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		cfg.hTotal = 8'h13;
		cfg.hActive = 8'h0C;
		cfg.hSyncStart = 8'h0E;
		cfg.hSyncEnd = 8'h11;
		cfg.lastScan = 4'h1;
		cfg.lastRow = 7'h01;
		cfg.vFront = 8'h02;
		cfg.vSync = 8'h02;
		cfg.vBack = 8'h02;
		cfg.underlinePos = 4'h1;
		cfg.cursorLast = 4'h1;
		cfg.graphics = 1'b1;
		cfg.displayOn = 1'b1;
		cfg.startAddr = 16'h0123;
		cfg.cursorAddr = 16'h0125;
		tick(8);
		rstn = 1'b1;
		tick(1);
		chk({irqOen, pin2, pin3, video.blank}, 4'hF);
		t_raster();
		t_flags();
		t_lock();
		t_irq();
		t_hold();
		t_indep();
		t_shared(crt_pkg::BUF_TRANSP);
		t_shared(crt_pkg::BUF_SHARED);
		t_rowbuf();
		wrap_up();
	end
	// The tests need about 1800 cycles; 20000 leaves a wide margin for a hang.
	initial
	begin
		#160000;
		err_total++;
		wrap_up();
	end
endmodule
